// [bench/i2c_bus_partner.sv]
// bus partner: a master framing starts, bytes and stops on the lines
module i2c_bus_partner (
   // resolved clock level
   input  wire logic  scl_line,
   // pull-downs of this party, 1 pulls low
   output logic       scl_low,
   output logic       sda_low,
   // clock stretches that never ended
   output logic [7:0] timeouts
);
   timeunit 1ns;
   timeprecision 1ns;

   // both lines released until a frame starts
   initial begin
      scl_low = 1'h0;
      sda_low = 1'h0;
      timeouts = 8'h00;
   end

   // the far side may stretch the clock, so wait on the line itself
   task automatic wait_high();
      int n;
      n = 0;
      while (scl_line !== 1'h1 && n < 400) begin
         #100;
         n++;
      end
      if (n == 400) begin
         timeouts = timeouts + 8'h01;
      end
   endtask

   task automatic data_low();
      sda_low = 1'h1;
   endtask

   task automatic start_cond();
      sda_low = 1'h1;
      #400;
      scl_low = 1'h1;
      #200;
   endtask

   task automatic stop_cond();
      sda_low = 1'h1;
      #200;
      scl_low = 1'h0;
      wait_high();
      #400;
      sda_low = 1'h0;
      #800;
   endtask

   // n clocks of 800 ns, bits sent from bit 8 down
   task automatic clocks(input int n, input logic [8:0] bits);
      for (int i = 0; i < n; i++) begin
         sda_low = ~bits[8 - i];
         #200;
         scl_low = 1'h0;
         wait_high();
         #400;
         scl_low = 1'h1;
         #200;
      end
   endtask
endmodule

// [bench/tb_i2c_control_register_logic.sv]
// self-checking bench for the i2c control register logic
module tb_i2c_control_register_logic;
   timeunit 1ns;
   timeprecision 1ns;

   logic                  clk_sys     = 1'h0;
   logic                  rst         = 1'h1;
   logic [15:0]           cpu_addr    = 16'h0000;
   logic                  cpu_wr_byte = 1'h0;
   logic                  cpu_wr_bit  = 1'h0;
   logic [2:0]            cpu_bit_sel = 3'h0;
   logic [7:0]            cpu_wdata   = 8'h00;
   logic                  cpu_rd      = 1'h0;
   i2c_ctrl_pkg::events_s eng_ev      = '0;
   logic [7:0]            rdata;
   logic [7:0]            rv;
   logic [7:0]            tmo;
   wire                   scl_line;
   wire                   sda_line;
   logic                  scl_low;
   logic                  sda_low;
   logic                  scl_oe_n;
   logic                  sda_oe_n;
   logic                  scl_o;
   logic                  sda_o;
   logic                  irq;
   i2c_ctrl_pkg::ctrl_s   ctrl;
   i2c_ctrl_pkg::status_s st;
   i2c_ctrl_pkg::flags_s  fl;
   int                    errors      = 0;
   int                    n_tests     = 0;
   int                    n_irq       = 0;
   localparam logic [15:0] A = i2c_ctrl_pkg::CTRL_ADDR;

   always #50 clk_sys = ~clk_sys;

   // open drain with pull-ups
   assign scl_line = ~(scl_low | ~scl_oe_n);
   assign sda_line = ~(sda_low | ~sda_oe_n);

   i2c_control_register_logic DUT (
      .clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr_byte(cpu_wr_byte),
      .cpu_wr_bit(cpu_wr_bit), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata),
      .cpu_rd(cpu_rd), .cpu_rdata_q(rdata), .eng_ev(eng_ev),
      .serial_clock_line_i(scl_line), .serial_clock_line_o_q(scl_o),
      .serial_clock_line_oe_n_q(scl_oe_n), .serial_data_line_i(sda_line),
      .serial_data_line_o_q(sda_o), .serial_data_line_oe_n_q(sda_oe_n),
      .i2c_control_q(ctrl), .interface_status_register_q(st), .flags_q(fl),
      .interface_interrupt_request_q(irq)
   );

   i2c_bus_partner u_bus (
      .scl_line(scl_line), .scl_low(scl_low), .sda_low(sda_low), .timeouts(tmo)
   );

   always @(posedge clk_sys) begin
      if (irq === 1'h1) begin
         n_irq <= n_irq + 1;
      end
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic await_ok(input logic ok);
      if (ok !== 1'h1) begin
         errors++;
         $display("unexpected at %0t: wait ran out", $time);
         summarize();
      end
   endtask

   // inputs move 10 ns after the edge, outputs read there too
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         #10;
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      tick(1);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr_byte = 1'h1;
      tick(1);
      cpu_wr_byte = 1'h0;
   endtask

   task automatic wbit(input logic [2:0] sel, input logic v);
      tick(1);
      cpu_addr = A;
      cpu_bit_sel = sel;
      cpu_wdata = {7'h00, v};
      cpu_wr_bit = 1'h1;
      tick(1);
      cpu_wr_bit = 1'h0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      tick(1);
      cpu_addr = a;
      cpu_rd = 1'h1;
      tick(1);
      cpu_rd = 1'h0;
      d = rdata;
   endtask

   task automatic ev(input logic [5:0] e);
      tick(1);
      eng_ev = i2c_ctrl_pkg::events_s'(e);
      tick(1);
      eng_ev = '0;
   endtask

   task automatic await_start();
      for (int i = 0; i < 10 && st.start_detected_flag !== 1'h1; i++) tick(1);
      await_ok(st.start_detected_flag);
   endtask

   task automatic await_scl(input logic lvl);
      for (int i = 0; i < 10 && scl_oe_n !== lvl; i++) tick(1);
      await_ok(scl_oe_n === lvl);
   endtask

   initial begin
      repeat (40000) @(posedge clk_sys);
      errors++;
      $display("unexpected at %0t: run hung", $time);
      summarize();
   end

   initial begin
      tick(6);
      rst = 1'h0;
      check(ctrl, i2c_ctrl_pkg::CTRL_RESET);
      check(8'({irq, scl_oe_n, sda_oe_n}), 8'h03);
      wr(A, 8'h7C);
      rd(A, rv);
      check(rv, 8'h1C);
      wr(16'hFFA7, 8'hFF);
      rd(16'hFFA5, rv);
      check(rv, 8'h1C);
      wbit(3'h3, 1'h0);
      check(ctrl, 8'h14);
      // enabling with data held low must find a start at once
      u_bus.data_low();
      wr(A, 8'h80);
      await_start();
      wbit(3'h6, 1'h1);
      tick(3);
      check(st, 8'h00);
      u_bus.stop_cond();
      tick(6);
      check(8'(n_irq), 8'h00);
      wr(A, 8'h00);
      wr(A, 8'h94);
      rd(A, rv);
      check(rv, 8'h94);
      // engaged transfer abandoned by the exit bit
      u_bus.start_cond();
      await_start();
      ev(6'h2C);
      wbit(3'h1, 1'h1);
      wbit(3'h0, 1'h1);
      check(ctrl, 8'h97);
      check(st, 8'hB2);
      wbit(3'h6, 1'h1);
      tick(3);
      check(ctrl, 8'h94);
      check(st, 8'h00);
      check(8'({scl_oe_n, sda_oe_n}), 8'h03);
      wbit(3'h6, 1'h0);
      tick(2);
      check(ctrl, 8'h94);
      u_bus.stop_cond();
      tick(6);
      check(8'(n_irq), 8'h01);
      // address byte: wait at the ninth fall, sent as transmitter
      u_bus.start_cond();
      ev(6'h04);
      u_bus.clocks(9, 9'h0A5);
      await_scl(1'h0);
      check(8'({scl_o, sda_o}), 8'h00);
      tick(2);
      check(8'(n_irq), 8'h02);
      ev(6'h02);
      wbit(3'h5, 1'h1);
      await_scl(1'h1);
      check(8'({st.transmit_status_flag, sda_oe_n}), 8'h01);
      check(ctrl, 8'h94);
      // data byte: wait at the eighth fall, then acknowledge
      u_bus.clocks(8, 9'h0AA);
      await_scl(1'h0);
      tick(2);
      check(8'(n_irq), 8'h03);
      // wait timing moved to the ninth fall while the wait is pending
      wbit(3'h3, 1'h1);
      wbit(3'h5, 1'h1);
      await_scl(1'h1);
      check(8'(sda_oe_n), 8'h00);
      u_bus.clocks(1, 9'h1FF);
      tick(4);
      check(8'(sda_oe_n), 8'h01);
      await_scl(1'h0);
      check(8'(n_irq), 8'h04);
      wbit(3'h5, 1'h1);
      await_scl(1'h1);
      u_bus.stop_cond();
      tick(6);
      check(8'(n_irq), 8'h05);
      // disable with the bus busy and a failed start pending
      u_bus.start_cond();
      ev(6'h01);
      tick(2);
      check(8'(fl.bus_busy_flag), 8'h01);
      check(8'(fl), 8'h0C);
      wr(A, 8'h00);
      tick(2);
      check(8'(fl), 8'h00);
      check(st, 8'h00);
      u_bus.stop_cond();
      u_bus.start_cond();
      tick(6);
      check(st, 8'h00);
      check(tmo, 8'h00);
      summarize();
   end
endmodule

// [verilog/i2c_control_register_logic.sv]
// i2c control register with enable, exit, wait cancel and line control
module i2c_control_register_logic (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // processor memory access
   input  wire logic [15:0]            cpu_addr,
   input  wire logic                   cpu_wr_byte,
   input  wire logic                   cpu_wr_bit,
   input  wire logic [2:0]             cpu_bit_sel,
   input  wire logic [7:0]             cpu_wdata,
   input  wire logic                   cpu_rd,
   output logic      [7:0]             cpu_rdata_q,
   // protocol engine events
   input  wire i2c_ctrl_pkg::events_s  eng_ev,
   // bus pins, open drain
   input  wire logic                   serial_clock_line_i,
   output logic                        serial_clock_line_o_q,
   output logic                        serial_clock_line_oe_n_q,
   input  wire logic                   serial_data_line_i,
   output logic                        serial_data_line_o_q,
   output logic                        serial_data_line_oe_n_q,
   // state toward the rest of the interface
   output i2c_ctrl_pkg::ctrl_s         i2c_control_q,
   output i2c_ctrl_pkg::status_s       interface_status_register_q,
   output i2c_ctrl_pkg::flags_s        flags_q,
   output logic                        interface_interrupt_request_q
);

   i2c_ctrl_pkg::ctrl_s       ctrl_d;
   i2c_ctrl_pkg::status_s     stat_d;
   i2c_ctrl_pkg::flags_s      flg_d;
   i2c_ctrl_pkg::link_state_e state_q;
   i2c_ctrl_pkg::link_state_e state_d;
   logic [3:0]                bit_cnt_q;
   logic [3:0]                bit_cnt_d;
   logic                      addr_phase_q;
   logic                      addr_phase_d;
   logic                      start_seen_q;
   logic                      start_seen_d;
   logic                      stop_seen_q;
   logic                      stop_seen_d;
   logic                      irq_d;
   logic                      ack_d;
   logic [7:0]                rdata_d;
   logic [7:0]                wr_val;
   logic [3:0]                wait_pt;
   logic                      hit;
   logic                      exit_exec;
   logic                      wrel_exec;
   logic                      scl_s1_q;
   logic                      scl_s2_q;
   logic                      scl_p_q;
   logic                      sda_s1_q;
   logic                      sda_s2_q;
   logic                      sda_p_q;
   logic                      start_det;
   logic                      stop_det;
   logic                      scl_fall;
   logic                      scl_rise;

   // previous samples forced high while disabled, so data held low at enable reads as a start
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_p_q  <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_p_q  <= 1'b1;
      end else begin
         scl_s1_q <= serial_clock_line_i;
         scl_s2_q <= scl_s1_q;
         sda_s1_q <= serial_data_line_i;
         sda_s2_q <= sda_s1_q;
         scl_p_q  <= i2c_control_q.operation_enable_bit ? scl_s2_q : 1'b1;
         sda_p_q  <= i2c_control_q.operation_enable_bit ? sda_s2_q : 1'b1;
      end
   end

   assign start_det = i2c_control_q.operation_enable_bit & scl_s2_q & scl_p_q
                      & sda_p_q & ~sda_s2_q;
   assign stop_det  = i2c_control_q.operation_enable_bit & scl_s2_q & scl_p_q
                      & ~sda_p_q & sda_s2_q;
   assign scl_fall  = i2c_control_q.operation_enable_bit & scl_p_q & ~scl_s2_q;
   assign scl_rise  = i2c_control_q.operation_enable_bit & ~scl_p_q & scl_s2_q;
   assign hit       = (cpu_addr == i2c_ctrl_pkg::CTRL_ADDR);

   always_comb begin
      ctrl_d       = i2c_control_q;
      stat_d       = interface_status_register_q;
      flg_d        = flags_q;
      state_d      = state_q;
      bit_cnt_d    = bit_cnt_q;
      addr_phase_d = addr_phase_q;
      start_seen_d = start_seen_q;
      stop_seen_d  = stop_seen_q;
      irq_d        = 1'b0;
      wr_val       = 8'h00;
      rdata_d      = cpu_rdata_q;
      // self-clearing bits act only while enabled, one cycle after the write
      exit_exec = i2c_control_q.operation_enable_bit
                  & i2c_control_q.communication_exit_bit;
      wrel_exec = i2c_control_q.operation_enable_bit
                  & i2c_control_q.wait_cancel_bit;
      wait_pt   = (addr_phase_q | i2c_control_q.wait_timing_select) ?
                  i2c_ctrl_pkg::CLK_NINTH : i2c_ctrl_pkg::CLK_EIGHTH;
      ctrl_d.communication_exit_bit = 1'b0;
      ctrl_d.wait_cancel_bit        = 1'b0;
      if (!i2c_control_q.operation_enable_bit) begin
         state_d      = i2c_ctrl_pkg::ST_OFF;
         stat_d       = '0;
         flg_d        = '0;
         bit_cnt_d    = i2c_ctrl_pkg::CNT_RESET;
         addr_phase_d = 1'b1;
         start_seen_d = 1'b0;
         stop_seen_d  = 1'b0;
      end else begin
         if (state_q == i2c_ctrl_pkg::ST_OFF) begin
            state_d = i2c_ctrl_pkg::ST_IDLE;
         end
         flg_d.clock_level_detect = scl_s2_q;
         flg_d.data_level_detect  = sda_s2_q;
         // clears first so a same-cycle set wins
         if (exit_exec) begin
            stat_d.master_status_flag        = 1'b0;
            stat_d.extension_code_flag       = 1'b0;
            stat_d.address_match_flag        = 1'b0;
            stat_d.transmit_status_flag      = 1'b0;
            stat_d.acknowledge_detected_flag = 1'b0;
            stat_d.start_detected_flag       = 1'b0;
            ctrl_d.start_trigger             = 1'b0;
            ctrl_d.stop_trigger              = 1'b0;
            start_seen_d                     = 1'b0;
            stop_seen_d                      = 1'b0;
         end
         if (state_q == i2c_ctrl_pkg::ST_WAIT && wrel_exec) begin
            state_d = i2c_ctrl_pkg::ST_XFER;
            if (bit_cnt_q == i2c_ctrl_pkg::CLK_NINTH) begin
               bit_cnt_d    = i2c_ctrl_pkg::CNT_RESET;
               addr_phase_d = 1'b0;
               stat_d.transmit_status_flag = 1'b0;
            end
         end
         if (eng_ev.master_set) stat_d.master_status_flag = 1'b1;
         if (eng_ev.arb_lost_set) stat_d.arbitration_lost = 1'b1;
         if (eng_ev.ext_code_set) stat_d.extension_code_flag = 1'b1;
         if (eng_ev.addr_match_set) stat_d.address_match_flag = 1'b1;
         if (eng_ev.transmit_set) stat_d.transmit_status_flag = 1'b1;
         if (eng_ev.start_fail_set) flg_d.start_request_failed_flag = 1'b1;
         if (scl_fall && (state_q == i2c_ctrl_pkg::ST_XFER
                          || state_q == i2c_ctrl_pkg::ST_STANDBY)) begin
            bit_cnt_d = 4'(bit_cnt_q + 4'h1);
            if (state_q == i2c_ctrl_pkg::ST_XFER && bit_cnt_d == wait_pt) begin
               state_d = i2c_ctrl_pkg::ST_WAIT;
               irq_d   = 1'b1;
            end else if (bit_cnt_d == i2c_ctrl_pkg::CLK_NINTH) begin
               bit_cnt_d    = i2c_ctrl_pkg::CNT_RESET;
               addr_phase_d = 1'b0;
            end
         end
         if (scl_rise && bit_cnt_q == i2c_ctrl_pkg::CLK_EIGHTH && !sda_s2_q
             && serial_data_line_oe_n_q) begin
            stat_d.acknowledge_detected_flag = 1'b1;
         end
         if (start_det) begin
            flg_d.bus_busy_flag        = 1'b1;
            stat_d.start_detected_flag = 1'b1;
            stat_d.stop_detected       = 1'b0;
            bit_cnt_d                  = i2c_ctrl_pkg::CNT_START;
            addr_phase_d               = 1'b1;
            if (state_q == i2c_ctrl_pkg::ST_STANDBY) begin
               start_seen_d = 1'b1;
            end else begin
               state_d = i2c_ctrl_pkg::ST_XFER;
            end
         end
         if (stop_det) begin
            flg_d.bus_busy_flag  = 1'b0;
            stat_d.stop_detected = 1'b1;
            irq_d                = i2c_control_q.stop_interrupt_enable;
            if (state_q == i2c_ctrl_pkg::ST_STANDBY) begin
               stop_seen_d = 1'b1;
            end else begin
               state_d = i2c_ctrl_pkg::ST_IDLE;
            end
         end
         if (state_q == i2c_ctrl_pkg::ST_STANDBY
             && ((stop_seen_q && eng_ev.master_set)
                 || (start_seen_q && (eng_ev.addr_match_set || eng_ev.ext_code_set)))) begin
            state_d = i2c_ctrl_pkg::ST_XFER;
         end
         if (exit_exec) begin
            state_d = i2c_ctrl_pkg::ST_STANDBY;
         end
      end
      // processor write wins over the self-clear of the same cycle
      if (hit && (cpu_wr_byte || cpu_wr_bit)) begin
         wr_val = ctrl_d;
         if (cpu_wr_byte) begin
            wr_val = cpu_wdata;
         end else begin
            wr_val[cpu_bit_sel] = cpu_wdata[0];
         end
         // exit and cancel only stick when enable is set before and after
         if (!(i2c_control_q.operation_enable_bit && wr_val[i2c_ctrl_pkg::POS_ENABLE])) begin
            wr_val[i2c_ctrl_pkg::POS_EXIT] = 1'b0;
            wr_val[i2c_ctrl_pkg::POS_WREL] = 1'b0;
         end
         ctrl_d = wr_val;
      end
      ack_d = (state_d == i2c_ctrl_pkg::ST_XFER) && (bit_cnt_d == i2c_ctrl_pkg::CLK_EIGHTH)
              && ctrl_d.acknowledge_enable
              && (!addr_phase_d || stat_d.extension_code_flag);
      if (hit && cpu_rd) begin
         rdata_d = i2c_control_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         i2c_control_q                 <= i2c_ctrl_pkg::CTRL_RESET;
         interface_status_register_q   <= '0;
         flags_q                       <= '0;
         state_q                       <= i2c_ctrl_pkg::ST_OFF;
         bit_cnt_q                     <= i2c_ctrl_pkg::CNT_RESET;
         addr_phase_q                  <= 1'b1;
         start_seen_q                  <= 1'b0;
         stop_seen_q                   <= 1'b0;
         interface_interrupt_request_q <= 1'b0;
         serial_clock_line_oe_n_q      <= 1'b1;
         serial_data_line_oe_n_q       <= 1'b1;
         serial_clock_line_o_q         <= 1'b0;
         serial_data_line_o_q          <= 1'b0;
         cpu_rdata_q                   <= 8'h00;
      end else begin
         i2c_control_q                 <= ctrl_d;
         interface_status_register_q   <= stat_d;
         flags_q                       <= flg_d;
         state_q                       <= state_d;
         bit_cnt_q                     <= bit_cnt_d;
         addr_phase_q                  <= addr_phase_d;
         start_seen_q                  <= start_seen_d;
         stop_seen_q                   <= stop_seen_d;
         interface_interrupt_request_q <= irq_d;
         // wait holds clock low; standby and off leave both lines released
         serial_clock_line_oe_n_q      <= (state_d != i2c_ctrl_pkg::ST_WAIT);
         serial_data_line_oe_n_q       <= ~ack_d;
         serial_clock_line_o_q         <= 1'b0;
         serial_data_line_o_q          <= 1'b0;
         cpu_rdata_q                   <= rdata_d;
      end
   end

   property p_reset_zero;
      @(posedge clk_sys) rst |=> (i2c_control_q == 8'h00) && serial_clock_line_oe_n_q;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset");

   property p_bit_write;
      @(posedge clk_sys) disable iff (rst)
      (hit && cpu_wr_bit && cpu_bit_sel != 3'h6 && cpu_bit_sel != 3'h5)
      |=> i2c_control_q[$past(cpu_bit_sel)] == $past(cpu_wdata[0]);
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("single bit write lost");

   property p_disabled_clear;
      @(posedge clk_sys) disable iff (rst)
      !i2c_control_q.operation_enable_bit |=> interface_status_register_q == '0
      && flags_q == '0 && !i2c_control_q.communication_exit_bit;
   endproperty
   a_disabled_clear: assert property (p_disabled_clear) else $error("state kept while disabled");

   property p_exit;
      @(posedge clk_sys) disable iff (rst)
      (exit_exec && !start_det && !cpu_wr_byte && !cpu_wr_bit)
      |=> state_q == i2c_ctrl_pkg::ST_STANDBY && serial_clock_line_oe_n_q
      && serial_data_line_oe_n_q && !i2c_control_q.start_trigger
      && !interface_status_register_q.start_detected_flag;
   endproperty
   a_exit: assert property (p_exit) else $error("exit did not release and clear");

   property p_wait_cancel;
      @(posedge clk_sys) disable iff (rst)
      (state_q == i2c_ctrl_pkg::ST_WAIT && wrel_exec && !exit_exec && !cpu_wr_bit && !cpu_wr_byte)
      |=> state_q == i2c_ctrl_pkg::ST_XFER && serial_clock_line_oe_n_q
      && !i2c_control_q.wait_cancel_bit;
   endproperty
   a_wait_cancel: assert property (p_wait_cancel) else $error("wait not cancelled");

   property p_trc_release;
      @(posedge clk_sys) disable iff (rst)
      (state_q == i2c_ctrl_pkg::ST_WAIT && wrel_exec && !eng_ev.transmit_set
       && bit_cnt_q == i2c_ctrl_pkg::CLK_NINTH)
      |=> !interface_status_register_q.transmit_status_flag && serial_data_line_oe_n_q;
   endproperty
   a_trc_release: assert property (p_trc_release) else $error("data not released");

   property p_stop_irq;
      @(posedge clk_sys) disable iff (rst)
      stop_det |=> interface_interrupt_request_q == $past(i2c_control_q.stop_interrupt_enable);
   endproperty
   a_stop_irq: assert property (p_stop_irq) else $error("stop interrupt wrong");

   property p_wait_point;
      @(posedge clk_sys) disable iff (rst)
      (state_q == i2c_ctrl_pkg::ST_WAIT && $past(state_q) == i2c_ctrl_pkg::ST_XFER)
      |-> interface_interrupt_request_q && !serial_clock_line_oe_n_q
      && bit_cnt_q == (($past(i2c_control_q.wait_timing_select) || $past(addr_phase_q)) ?
                       4'h9 : 4'h8);
   endproperty
   a_wait_point: assert property (p_wait_point) else $error("wait at wrong clock");

   property p_ack;
      @(posedge clk_sys) disable iff (rst)
      !serial_data_line_oe_n_q |-> state_q == i2c_ctrl_pkg::ST_XFER
      && bit_cnt_q == 4'h8 && i2c_control_q.acknowledge_enable
      && (!addr_phase_q || interface_status_register_q.extension_code_flag);
   endproperty
   a_ack: assert property (p_ack) else $error("data driven outside acknowledge");

   property p_enable_start;
      @(posedge clk_sys) disable iff (rst)
      (i2c_control_q.operation_enable_bit && !$past(i2c_control_q.operation_enable_bit)
       && scl_s2_q && !sda_s2_q && !exit_exec)
      |=> interface_status_register_q.start_detected_flag && flags_q.bus_busy_flag;
   endproperty
   a_enable_start: assert property (p_enable_start) else $error("start not seen at enable");

endmodule

// [verilog/i2c_ctrl_pkg.sv]
// constants and carrier types for the i2c control register logic
package i2c_ctrl_pkg;

   localparam logic [15:0] CTRL_ADDR  = 16'hFFA6;
   localparam logic [7:0]  CTRL_RESET = 8'h00;
   localparam logic [2:0]  POS_ENABLE = 3'h7;
   localparam logic [2:0]  POS_EXIT   = 3'h6;
   localparam logic [2:0]  POS_WREL   = 3'h5;
   localparam logic [3:0]  CNT_RESET  = 4'h0;
   // the clock fall that closes a start is not a data clock: it wraps this to zero
   localparam logic [3:0]  CNT_START  = 4'hF;
   localparam logic [3:0]  CLK_EIGHTH = 4'h8;
   localparam logic [3:0]  CLK_NINTH  = 4'h9;

   // bit 7 down to bit 0
   typedef struct packed {
      logic operation_enable_bit;
      logic communication_exit_bit;
      logic wait_cancel_bit;
      logic stop_interrupt_enable;
      logic wait_timing_select;
      logic acknowledge_enable;
      logic stop_trigger;
      logic start_trigger;
   } ctrl_s;

   typedef struct packed {
      logic master_status_flag;
      logic arbitration_lost;
      logic extension_code_flag;
      logic address_match_flag;
      logic transmit_status_flag;
      logic acknowledge_detected_flag;
      logic start_detected_flag;
      logic stop_detected;
   } status_s;

   typedef struct packed {
      logic start_request_failed_flag;
      logic bus_busy_flag;
      logic clock_level_detect;
      logic data_level_detect;
   } flags_s;

   // one-cycle pulses from the shift and address logic
   typedef struct packed {
      logic master_set;
      logic arb_lost_set;
      logic ext_code_set;
      logic addr_match_set;
      logic transmit_set;
      logic start_fail_set;
   } events_s;

   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_IDLE    = 3'b001,
      ST_XFER    = 3'b010,
      ST_WAIT    = 3'b011,
      ST_STANDBY = 3'b100
   } link_state_e;

endpackage
